// File: design/dts_params.svh
// Register map, field positions, reset values and interrupt bits
// Operation
// - Initiate waits for selectable start trigger, default immediate
// - Start trigger begins pretrigger sample storage
// - Reference wait only after full pretrigger count
// - Reference trigger: posttrigger samples, then record done
// - Later records use advance source; count configurable
// - Pre/post split from reference position percent
// - Ignore triggers during holdoff, default zero; only the reference trigger is held off
// - Wait trigger delay before acquiring, default zero
// - Reference slope rising or falling, default rising
// - Analog trigger fires on threshold crossing
// - Digital trigger rejected in equivalent-time mode
// - Real-time-only flag true by default
// - FIR coefficients applied only when enabled
// - Bandwidth 0 default, -1 full
// - Commit moves pending settings to active now
// - Abort returns sequencer to idle
// - Status reports complete, in progress, unknown
`ifndef DTS_PARAMS_SVH
`define DTS_PARAMS_SVH
`define DTS_A_CTRL      8'h00
`define DTS_A_STATUS    8'h04
`define DTS_A_TRIG      8'h08
`define DTS_A_LEVEL     8'h0c
`define DTS_A_RECLEN    8'h10
`define DTS_A_REFPOS    8'h14
`define DTS_A_NREC      8'h18
`define DTS_A_HOLDOFF   8'h1c
`define DTS_A_DELAY     8'h20
`define DTS_A_BW        8'h24
`define DTS_A_FIRCTL    8'h28
`define DTS_A_FIRCOEF   8'h2c
`define DTS_A_IRQST     8'h30
`define DTS_A_IRQMSK    8'h34
`define DTS_A_ACTIVE    8'h38
// Control bits
`define DTS_C_INIT      0
`define DTS_C_ABORT     1
`define DTS_C_COMMIT    2
`define DTS_C_SWTRIG    3
// Trigger config fields
`define DTS_T_TYPE_LO   0
`define DTS_T_SLOPE     2
`define DTS_T_START_LO  4
`define DTS_T_ADV_LO    6
`define DTS_T_RTONLY    8
`define DTS_T_EQT       9
// Reset values
`define DTS_TRIG_RST    32'h0000_0100
`define DTS_RECLEN_RST  16'h0400
`define DTS_REFPOS_RST  7'h32
`define DTS_NREC_RST    16'h0001
`define DTS_BW_DEFAULT  32'h0000_0000
`define DTS_BW_FULL     32'hffff_ffff
`define DTS_NCOEF       8
// Interrupt bits
`define DTS_I_DONE      0
`define DTS_I_REFTRIG   1
`define DTS_I_REJECT    2
`endif

// File: design/dts_pkg.sv
// Types of the trigger sequencer
package dts_pkg;
  typedef enum logic [2:0] {
    DTS_IDLE  = 3'b000,
    DTS_ARM   = 3'b001,
    DTS_PRE   = 3'b011,
    DTS_REFW  = 3'b010,
    DTS_DLY   = 3'b110,
    DTS_POST  = 3'b111,
    DTS_DONE  = 3'b101
  } dts_state_t;
  typedef enum logic [1:0] {
    DTS_SRC_IMM = 2'b00,
    DTS_SRC_EXT = 2'b01,
    DTS_SRC_SW  = 2'b10
  } dts_src_t;
  typedef enum logic [1:0] {
    DTS_TT_IMM  = 2'b00,
    DTS_TT_DIG  = 2'b01,
    DTS_TT_ANA  = 2'b10,
    DTS_TT_SW   = 2'b11
  } dts_ttype_t;
  typedef enum logic [1:0] {
    DTS_ST_UNKNOWN  = 2'b00,
    DTS_ST_PROGRESS = 2'b01,
    DTS_ST_COMPLETE = 2'b10
  } dts_acq_t;
endpackage : dts_pkg

// File: design/dts_fir.sv
// Equalization FIR filter with bypass
`timescale 1ns/1ns
`default_nettype none
`include "dts_params.svh"
module dts_fir (
  input  wire logic                      clk_i,
  input  wire logic                      srst_i,
  input  wire logic                      en_i,
  input  wire logic [16*`DTS_NCOEF-1:0]  coef_i,
  input  wire logic signed [15:0]        smp_i,
  output logic signed [15:0]             smp_o
);
  logic signed [15:0] tap_q [`DTS_NCOEF];
  logic signed [35:0] acc;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < `DTS_NCOEF; i++) tap_q[i] <= 16'sh0000;
    end else begin
      tap_q[0] <= smp_i;
      for (int i = 1; i < `DTS_NCOEF; i++) tap_q[i] <= tap_q[i-1];
    end
  end
  // Coefficients are Q1.15 so the range is just under +1 to -1
  always_comb begin
    acc = 36'sh0;
    for (int i = 0; i < `DTS_NCOEF; i++)
      acc = acc + 36'(tap_q[i] * $signed(coef_i[16*i +: 16]));
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) smp_o <= 16'sh0000;
    else if (en_i) smp_o <= acc[30:15];
    else smp_o <= tap_q[0];
  end
endmodule : dts_fir
`default_nettype wire

// File: design/dts_top.sv
// Acquisition trigger sequencer with AXI4-Lite register slave
`timescale 1ns/1ns
`default_nettype none
`include "dts_params.svh"
module dts_top (
  input  wire logic               CLOCK_I,
  input  wire logic               SRST_I,
  input  wire logic [7:0]         S_AXI_AWADDR_I,
  input  wire logic               S_AXI_AWVALID_I,
  output logic                    S_AXI_AWREADY_O,
  input  wire logic [31:0]        S_AXI_WDATA_I,
  input  wire logic [3:0]         S_AXI_WSTRB_I,
  input  wire logic               S_AXI_WVALID_I,
  output logic                    S_AXI_WREADY_O,
  output logic [1:0]              S_AXI_BRESP_O,
  output logic                    S_AXI_BVALID_O,
  input  wire logic               S_AXI_BREADY_I,
  input  wire logic [7:0]         S_AXI_ARADDR_I,
  input  wire logic               S_AXI_ARVALID_I,
  output logic                    S_AXI_ARREADY_O,
  output logic [31:0]             S_AXI_RDATA_O,
  output logic [1:0]              S_AXI_RRESP_O,
  output logic                    S_AXI_RVALID_O,
  input  wire logic               S_AXI_RREADY_I,
  input  wire logic               START_TRIG_I,
  input  wire logic               ADV_TRIG_I,
  input  wire logic               DIG_TRIG_I,
  input  wire logic signed [15:0] TRIG_SMP_I,
  input  wire logic signed [15:0] ADC_SMP_I,
  output logic signed [15:0]      SMP_O,
  output logic                    SMP_VALID_O,
  output logic                    REC_DONE_O,
  output logic [31:0]             BW_SEL_O,
  output logic                    IRQ_O
);
  logic               awv_q, wv_q, bv_q, rv_q;
  logic [7:0]         awa_q;
  logic [31:0]        wd_q, rd_q;
  logic [1:0]         bresp_q, rresp_q;
  logic               wr_go, rd_go;
  logic [31:0]        trig_p_q, trig_a_q, level_p_q, level_a_q;
  logic [15:0]        reclen_p_q, reclen_a_q, nrec_p_q, nrec_a_q;
  logic [6:0]         refpos_p_q, refpos_a_q;
  logic [31:0]        hold_p_q, hold_a_q, dly_p_q, dly_a_q;
  logic [31:0]        bw_p_q;
  logic               firen_p_q, firen_a_q;
  logic [16*`DTS_NCOEF-1:0] coef_p_q, coef_a_q;
  logic [2:0]         irq_st_q, irq_mk_q, irq_set;
  logic               init_p, abort_p, commit_p, swtrig_p, rej;
  logic               st_s1_q, st_s2_q, ad_s1_q, ad_s2_q, dg_s1_q, dg_s2_q;
  logic               dg_prev_q, ana_prev_q;
  logic               start_hit, adv_hit, ref_hit, ana_above;
  logic [15:0]        pre_cnt, post_cnt;
  logic [15:0]        cnt_q, rec_q;
  logic [31:0]        hold_q, dly_q;
  logic [1:0]         acq_q;
  logic signed [15:0] fir_smp;
  dts_pkg::dts_state_t st_q;

  function automatic logic pick_src(input logic [1:0] s, input logic ext,
                                    input logic sw);
    case (s)
      2'b00:   pick_src = 1'b1;
      2'b01:   pick_src = ext;
      2'b10:   pick_src = sw;
      default: pick_src = 1'b0;
    endcase
  endfunction : pick_src

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] d,
                                        input logic [3:0] b);
    for (int i = 0; i < 4; i++) if (b[i]) o[8*i +: 8] = d[8*i +: 8];
    merge = o;
  endfunction : merge

  // AXI4-Lite write path, address and data in either order
  assign S_AXI_AWREADY_O = !awv_q && !bv_q;
  assign S_AXI_WREADY_O  = !wv_q && !bv_q;
  assign wr_go = awv_q && wv_q && !bv_q;
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      awv_q <= 1'b0;
      wv_q  <= 1'b0;
      bv_q  <= 1'b0;
      awa_q <= 8'h00;
      wd_q  <= 32'h0;
    end else begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        awv_q <= 1'b1;
        awa_q <= S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        wv_q <= 1'b1;
        wd_q <= merge(32'h0, S_AXI_WDATA_I, S_AXI_WSTRB_I);
      end
      if (wr_go) begin
        awv_q <= 1'b0;
        wv_q  <= 1'b0;
        bv_q  <= 1'b1;
      end else if (bv_q && S_AXI_BREADY_I) begin
        bv_q <= 1'b0;
      end
    end
  end
  assign S_AXI_BVALID_O = bv_q;
  assign S_AXI_BRESP_O  = bresp_q;

  // Command pulses from the control register
  assign init_p   = wr_go && awa_q == `DTS_A_CTRL && wd_q[`DTS_C_INIT];
  assign abort_p  = wr_go && awa_q == `DTS_A_CTRL && wd_q[`DTS_C_ABORT];
  assign commit_p = wr_go && awa_q == `DTS_A_CTRL && wd_q[`DTS_C_COMMIT];
  assign swtrig_p = wr_go && awa_q == `DTS_A_CTRL && wd_q[`DTS_C_SWTRIG];
  // Digital type while equivalent-time is allowed and selected
  assign rej = wr_go && awa_q == `DTS_A_TRIG &&
               wd_q[`DTS_T_TYPE_LO +: 2] == 2'(dts_pkg::DTS_TT_DIG) &&
               wd_q[`DTS_T_EQT] && !wd_q[`DTS_T_RTONLY];

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      bresp_q    <= 2'b00;
      trig_p_q   <= `DTS_TRIG_RST;
      level_p_q  <= 32'h0;
      reclen_p_q <= `DTS_RECLEN_RST;
      refpos_p_q <= `DTS_REFPOS_RST;
      nrec_p_q   <= `DTS_NREC_RST;
      hold_p_q   <= 32'h0;
      dly_p_q    <= 32'h0;
      bw_p_q     <= `DTS_BW_DEFAULT;
      firen_p_q  <= 1'b0;
      coef_p_q   <= '0;
      irq_mk_q   <= 3'h0;
    end else if (wr_go) begin
      bresp_q <= 2'b00;
      case (awa_q)
        `DTS_A_CTRL:    ;
        `DTS_A_TRIG:    if (rej) bresp_q <= 2'b10;
                        else trig_p_q <= wd_q;
        `DTS_A_LEVEL:   level_p_q <= wd_q;
        `DTS_A_RECLEN:  if (wd_q[15:0] > 16'h0001) reclen_p_q <= wd_q[15:0];
                        else bresp_q <= 2'b10;
        `DTS_A_REFPOS:  if (wd_q <= 32'h0000_0064) refpos_p_q <= wd_q[6:0];
                        else bresp_q <= 2'b10;
        `DTS_A_NREC:    nrec_p_q <= wd_q[15:0];
        `DTS_A_HOLDOFF: hold_p_q <= wd_q;
        `DTS_A_DELAY:   dly_p_q <= wd_q;
        `DTS_A_BW:      bw_p_q <= wd_q;
        `DTS_A_FIRCTL:  firen_p_q <= wd_q[0];
        `DTS_A_FIRCOEF: coef_p_q[16*wd_q[18:16] +: 16] <= wd_q[15:0];
        `DTS_A_IRQMSK:  irq_mk_q <= wd_q[2:0];
        default:        bresp_q <= 2'b10;
      endcase
    end
  end

  // Active set follows the pending set on commit or on initiate from idle
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      trig_a_q   <= `DTS_TRIG_RST;
      level_a_q  <= 32'h0;
      reclen_a_q <= `DTS_RECLEN_RST;
      refpos_a_q <= `DTS_REFPOS_RST;
      nrec_a_q   <= `DTS_NREC_RST;
      hold_a_q   <= 32'h0;
      dly_a_q    <= 32'h0;
      firen_a_q  <= 1'b0;
      coef_a_q   <= '0;
      BW_SEL_O   <= `DTS_BW_DEFAULT;
    end else if (commit_p || (init_p && st_q == dts_pkg::DTS_IDLE)) begin
      trig_a_q   <= trig_p_q;
      level_a_q  <= level_p_q;
      reclen_a_q <= reclen_p_q;
      refpos_a_q <= refpos_p_q;
      nrec_a_q   <= nrec_p_q;
      hold_a_q   <= hold_p_q;
      dly_a_q    <= dly_p_q;
      firen_a_q  <= firen_p_q;
      coef_a_q   <= coef_p_q;
      BW_SEL_O   <= bw_p_q;
    end
  end

  // Read path
  assign S_AXI_ARREADY_O = !rv_q;
  assign rd_go = S_AXI_ARVALID_I && !rv_q;
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      rv_q    <= 1'b0;
      rd_q    <= 32'h0;
      rresp_q <= 2'b00;
    end else if (rd_go) begin
      rv_q    <= 1'b1;
      rresp_q <= 2'b00;
      case (S_AXI_ARADDR_I)
        `DTS_A_CTRL:    rd_q <= 32'h0;
        `DTS_A_STATUS:  rd_q <= {rec_q, 11'h0, st_q, acq_q};
        `DTS_A_TRIG:    rd_q <= trig_p_q;
        `DTS_A_LEVEL:   rd_q <= level_p_q;
        `DTS_A_RECLEN:  rd_q <= {16'h0, reclen_p_q};
        `DTS_A_REFPOS:  rd_q <= {25'h0, refpos_p_q};
        `DTS_A_NREC:    rd_q <= {16'h0, nrec_p_q};
        `DTS_A_HOLDOFF: rd_q <= hold_p_q;
        `DTS_A_DELAY:   rd_q <= dly_p_q;
        `DTS_A_BW:      rd_q <= bw_p_q;
        `DTS_A_FIRCTL:  rd_q <= {31'h0, firen_p_q};
        `DTS_A_FIRCOEF: rd_q <= 32'h0;
        `DTS_A_IRQST:   rd_q <= {29'h0, irq_st_q};
        `DTS_A_IRQMSK:  rd_q <= {29'h0, irq_mk_q};
        `DTS_A_ACTIVE:  rd_q <= trig_a_q;
        default: begin
          rd_q    <= 32'h0;
          rresp_q <= 2'b10;
        end
      endcase
    end else if (rv_q && S_AXI_RREADY_I) begin
      rv_q <= 1'b0;
    end
  end
  assign S_AXI_RVALID_O = rv_q;
  assign S_AXI_RDATA_O  = rd_q;
  assign S_AXI_RRESP_O  = rresp_q;

  // Sticky interrupt status, cleared by reading it; a new event wins
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) irq_st_q <= 3'h0;
    else if (rd_go && S_AXI_ARADDR_I == `DTS_A_IRQST) irq_st_q <= irq_set;
    else irq_st_q <= irq_st_q | irq_set;
  end
  assign IRQ_O = |(irq_st_q & irq_mk_q);

  // Trigger pin synchronisers
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      {st_s1_q, st_s2_q, ad_s1_q, ad_s2_q} <= 4'h0;
      {dg_s1_q, dg_s2_q, dg_prev_q, ana_prev_q} <= 4'h0;
    end else begin
      st_s1_q    <= START_TRIG_I;
      st_s2_q    <= st_s1_q;
      ad_s1_q    <= ADV_TRIG_I;
      ad_s2_q    <= ad_s1_q;
      dg_s1_q    <= DIG_TRIG_I;
      dg_s2_q    <= dg_s1_q;
      dg_prev_q  <= dg_s2_q;
      ana_prev_q <= ana_above;
    end
  end

  assign ana_above = TRIG_SMP_I > $signed(level_a_q[15:0]);
  assign start_hit = pick_src(trig_a_q[`DTS_T_START_LO +: 2], st_s2_q,
                              swtrig_p);
  assign adv_hit   = pick_src(trig_a_q[`DTS_T_ADV_LO +: 2], ad_s2_q,
                              swtrig_p);
  always_comb begin
    case (trig_a_q[`DTS_T_TYPE_LO +: 2])
      2'(dts_pkg::DTS_TT_IMM): ref_hit = 1'b1;
      2'(dts_pkg::DTS_TT_DIG): ref_hit = trig_a_q[`DTS_T_SLOPE] ?
          (dg_prev_q && !dg_s2_q) : (!dg_prev_q && dg_s2_q);
      2'(dts_pkg::DTS_TT_ANA): ref_hit = trig_a_q[`DTS_T_SLOPE] ?
          (ana_prev_q && !ana_above) : (!ana_prev_q && ana_above);
      default: ref_hit = swtrig_p;
    endcase
  end

  // Pretrigger share of the record from the position percent
  assign pre_cnt  = 16'((32'(reclen_a_q) * 32'(refpos_a_q)) / 32'd100);
  assign post_cnt = reclen_a_q - pre_cnt;

  // Sequencer
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      st_q   <= dts_pkg::DTS_IDLE;
      cnt_q  <= 16'h0;
      rec_q  <= 16'h0;
      hold_q <= 32'h0;
      dly_q  <= 32'h0;
      acq_q  <= 2'(dts_pkg::DTS_ST_UNKNOWN);
    end else if (abort_p) begin
      st_q  <= dts_pkg::DTS_IDLE;
      acq_q <= 2'(dts_pkg::DTS_ST_UNKNOWN);
    end else begin
      if (hold_q != 32'h0) hold_q <= hold_q - 32'h1;
      case (st_q)
        dts_pkg::DTS_IDLE: if (init_p) begin
          st_q  <= dts_pkg::DTS_ARM;
          rec_q <= 16'h0;
          acq_q <= 2'(dts_pkg::DTS_ST_PROGRESS);
        end
        dts_pkg::DTS_ARM:
          if ((rec_q == 16'h0) ? start_hit : adv_hit) begin
            st_q  <= dts_pkg::DTS_PRE;
            cnt_q <= 16'h0;
          end
        dts_pkg::DTS_PRE:
          if (cnt_q + 16'h1 >= pre_cnt) st_q <= dts_pkg::DTS_REFW;
          else cnt_q <= cnt_q + 16'h1;
        dts_pkg::DTS_REFW:
          if (ref_hit && hold_q == 32'h0) begin
            hold_q <= hold_a_q;
            dly_q  <= dly_a_q;
            st_q   <= dts_pkg::DTS_DLY;
          end
        dts_pkg::DTS_DLY:
          if (dly_q == 32'h0) begin
            st_q  <= dts_pkg::DTS_POST;
            cnt_q <= 16'h0;
          end else dly_q <= dly_q - 32'h1;
        dts_pkg::DTS_POST:
          if (cnt_q + 16'h1 >= post_cnt) st_q <= dts_pkg::DTS_DONE;
          else cnt_q <= cnt_q + 16'h1;
        dts_pkg::DTS_DONE:
          if (rec_q + 16'h1 >= nrec_a_q) begin
            st_q  <= dts_pkg::DTS_IDLE;
            acq_q <= 2'(dts_pkg::DTS_ST_COMPLETE);
          end else begin
            rec_q <= rec_q + 16'h1;
            st_q  <= dts_pkg::DTS_ARM;
          end
        default: st_q <= dts_pkg::DTS_IDLE;
      endcase
    end
  end

  // Bit 1 is reserved and always reads zero
  assign irq_set = {rej, 1'b0,
                    st_q == dts_pkg::DTS_DONE};

  dts_fir u_fir (
    .clk_i  (CLOCK_I),
    .srst_i (SRST_I),
    .en_i   (firen_a_q),
    .coef_i (coef_a_q),
    .smp_i  (ADC_SMP_I),
    .smp_o  (fir_smp)
  );

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      SMP_O       <= 16'sh0000;
      SMP_VALID_O <= 1'b0;
      REC_DONE_O  <= 1'b0;
    end else begin
      SMP_O       <= fir_smp;
      SMP_VALID_O <= st_q == dts_pkg::DTS_PRE || st_q == dts_pkg::DTS_POST;
      REC_DONE_O  <= st_q == dts_pkg::DTS_DONE;
    end
  end
endmodule : dts_top
`default_nettype wire

// File: sim/dts_monitor.sv
// Checker of bus handshakes and the record-done output at the top ports
`timescale 1ns/1ns
`default_nettype none
module dts_monitor (
  input wire logic        CLOCK_I,
  input wire logic        SRST_I,
  input wire logic [7:0]  S_AXI_AWADDR_I,
  input wire logic        S_AXI_AWVALID_I,
  input wire logic        S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic        S_AXI_WVALID_I,
  input wire logic        S_AXI_WREADY_O,
  input wire logic [1:0]  S_AXI_BRESP_O,
  input wire logic        S_AXI_BVALID_O,
  input wire logic        S_AXI_BREADY_I,
  input wire logic [7:0]  S_AXI_ARADDR_I,
  input wire logic        S_AXI_ARVALID_I,
  input wire logic        S_AXI_ARREADY_O,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic [1:0]  S_AXI_RRESP_O,
  input wire logic        S_AXI_RVALID_O,
  input wire logic        S_AXI_RREADY_I,
  input wire logic        REC_DONE_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SRST_I);
  wire logic wr_go = S_AXI_AWVALID_I && S_AXI_AWREADY_O &&
                     S_AXI_WVALID_I && S_AXI_WREADY_O;
  wire logic rd_go = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  wire logic b_err = S_AXI_BRESP_O == 2'h2;
  AST_B_ONCE: assert property (S_AXI_BVALID_O && S_AXI_BREADY_I |=>
    !S_AXI_BVALID_O) else $error("write answer repeated");
  AST_R_ONCE: assert property (S_AXI_RVALID_O && S_AXI_RREADY_I |=>
    !S_AXI_RVALID_O) else $error("read answer repeated");
  AST_W_BLOCK: assert property (S_AXI_BVALID_O |->
    !S_AXI_AWREADY_O && !S_AXI_WREADY_O) else $error("write not held off");
  AST_R_BLOCK: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
    else $error("read not held off");
  AST_B_NEXT: assert property (wr_go |-> ##2 S_AXI_BVALID_O)
    else $error("write answer late");
  AST_R_UNMAP: assert property (rd_go && S_AXI_ARADDR_I > 8'h38 |=>
    S_AXI_RVALID_O && S_AXI_RRESP_O == 2'h2 && S_AXI_RDATA_O == 32'h0)
    else $error("unmapped read answer wrong");
  AST_RECLEN: assert property (wr_go && S_AXI_AWADDR_I == 8'h10 &&
    S_AXI_WDATA_I <= 32'h1 |-> ##2 b_err) else $error("short length taken");
  AST_REFPOS: assert property (wr_go && S_AXI_AWADDR_I == 8'h14 &&
    S_AXI_WDATA_I > 32'h64 |-> ##2 b_err) else $error("position taken");
  AST_DIGREJ: assert property (wr_go && S_AXI_AWADDR_I == 8'h08 &&
    S_AXI_WDATA_I[1:0] == 2'h1 && S_AXI_WDATA_I[9] && !S_AXI_WDATA_I[8]
    |-> ##2 b_err) else $error("digital trigger taken");
  AST_DONE_PULSE: assert property (REC_DONE_O |=> !REC_DONE_O)
    else $error("record done too long");
  cover property (REC_DONE_O);
  cover property (S_AXI_BVALID_O && b_err);
  cover property (rd_go && S_AXI_ARADDR_I > 8'h38);
endmodule : dts_monitor
bind dts_top dts_monitor mon (.*);
`default_nettype wire

// File: sim/dts_trig_src.sv
// External trigger sources: three trigger pins and an analog sample
`timescale 1ns/1ns
`default_nettype none
module dts_trig_src (
  input  wire logic               clk_i,
  input  wire logic               srst_i,
  input  wire logic [2:0]         fire_i,
  input  wire logic signed [15:0] lvl_i,
  output logic                    start_o,
  output logic                    adv_o,
  output logic                    dig_o,
  output logic signed [15:0]      smp_o
);
  logic [2:0] cnt_q [3];
  // Pins stay high five clocks so the two-stage sync catches them
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 3; i++) begin
      if (srst_i) cnt_q[i] <= 3'h0;
      else if (fire_i[i]) cnt_q[i] <= 3'h5;
      else if (cnt_q[i] != 3'h0) cnt_q[i] <= cnt_q[i] - 3'h1;
    end
  end
  assign start_o = cnt_q[0] != 3'h0;
  assign adv_o   = cnt_q[1] != 3'h0;
  assign dig_o   = cnt_q[2] != 3'h0;
  always_ff @(posedge clk_i) smp_o <= lvl_i;
endmodule : dts_trig_src
`default_nettype wire

// File: sim/tb_digitizer_trigger_sequencer.sv
// Self-checking bench of the trigger sequencer over its register bus
`timescale 1ns/1ns
`default_nettype none
module tb_digitizer_trigger_sequencer;
  logic        CLOCK_I, SRST_I, S_AXI_AWVALID_I, S_AXI_WVALID_I;
  logic        S_AXI_BREADY_I, S_AXI_ARVALID_I, S_AXI_RREADY_I;
  logic        S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O;
  logic        S_AXI_ARREADY_O, S_AXI_RVALID_O, SMP_VALID_O;
  logic        REC_DONE_O, IRQ_O, START_TRIG_I, ADV_TRIG_I, DIG_TRIG_I;
  logic [7:0]  S_AXI_AWADDR_I, S_AXI_ARADDR_I;
  logic [31:0] S_AXI_WDATA_I, S_AXI_RDATA_O, BW_SEL_O, st;
  logic [3:0]  S_AXI_WSTRB_I;
  logic [1:0]  S_AXI_BRESP_O, S_AXI_RRESP_O;
  logic [2:0]  fire;
  logic signed [15:0] TRIG_SMP_I, ADC_SMP_I, SMP_O, lvl;
  int          bad_count, total_checks, cyc, nval, ndone, t0, tr [3];
  logic [7:0]  ra [8] = '{8'h08, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20,
                         8'h24, 8'h04};
  logic [31:0] rv [8] = '{32'h100, 32'h400, 32'h32, 32'h1, 32'h0,
                         32'h0, 32'h0, 32'h0};

  dts_top uut (.*);
  dts_trig_src src (.clk_i(CLOCK_I), .srst_i(SRST_I), .fire_i(fire),
    .lvl_i(lvl), .start_o(START_TRIG_I), .adv_o(ADV_TRIG_I),
    .dig_o(DIG_TRIG_I), .smp_o(TRIG_SMP_I));

  initial begin
    CLOCK_I = 1'b0;
    forever #5 CLOCK_I = ~CLOCK_I;
  end

  always @(posedge CLOCK_I) begin
    cyc <= cyc + 1;
    if (SMP_VALID_O === 1'b1) nval <= nval + 1;
    if (REC_DONE_O === 1'b1) ndone <= ndone + 1;
    if (cyc == 20000) begin
      bad_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (bad_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    S_AXI_AWADDR_I  <= a;
    S_AXI_WDATA_I   <= d;
    S_AXI_AWVALID_I <= 1'b1;
    S_AXI_WVALID_I  <= 1'b1;
    do begin
      @(posedge CLOCK_I);
      if (S_AXI_AWREADY_O) S_AXI_AWVALID_I <= 1'b0;
      if (S_AXI_WREADY_O) S_AXI_WVALID_I <= 1'b0;
    end while (S_AXI_BVALID_O !== 1'b1);
    chk("bresp", {30'h0, e}, {30'h0, S_AXI_BRESP_O});
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    S_AXI_ARADDR_I  <= a;
    S_AXI_ARVALID_I <= 1'b1;
    do begin
      @(posedge CLOCK_I);
      if (S_AXI_ARREADY_O) S_AXI_ARVALID_I <= 1'b0;
    end while (S_AXI_RVALID_O !== 1'b1);
    d = S_AXI_RDATA_O;
  endtask : rd

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk("register", e, d);
  endtask : rdc

  task automatic pulse(input int i);
    fire[i] <= 1'b1;
    @(posedge CLOCK_I);
    fire[i] <= 1'b0;
  endtask : pulse

  // Clears the counters while idle, then starts an acquisition
  task automatic arm(input logic [31:0] trig);
    wr(8'h08, trig, 2'h0);
    nval = 0;
    ndone = 0;
    wr(8'h00, 32'h1, 2'h0);
  endtask : arm

  initial begin
    SRST_I = 1'b1;
    {S_AXI_AWVALID_I, S_AXI_WVALID_I, S_AXI_ARVALID_I} = 3'h0;
    {S_AXI_BREADY_I, S_AXI_RREADY_I} = 2'h3;
    S_AXI_WSTRB_I = 4'hf;
    {S_AXI_AWADDR_I, S_AXI_ARADDR_I, S_AXI_WDATA_I} = 48'h0;
    ADC_SMP_I = 16'sh1234;
    fire = 3'h0;
    lvl = 16'sh0;
    {bad_count, total_checks, cyc, nval, ndone} = 160'h0;
    repeat (2) @(posedge CLOCK_I);
    SRST_I <= 1'b0;
    foreach (ra[i]) rdc(ra[i], rv[i]);
    wr(8'h34, 32'h5, 2'h0);
    wr(8'h10, 32'h1, 2'h2);
    wr(8'h14, 32'h65, 2'h2);
    wr(8'h08, 32'h201, 2'h2);
    wr(8'h3c, 32'h0, 2'h2);
    rdc(8'h40, 32'h0);
    rdc(8'h08, 32'h100);
    wr(8'h08, 32'h301, 2'h0);
    chk("irq", 32'h1, {31'h0, IRQ_O});
    rdc(8'h30, 32'h4);
    rdc(8'h30, 32'h0);
    chk("irq", 32'h0, {31'h0, IRQ_O});
    wr(8'h10, 32'h8, 2'h0);
    wr(8'h14, 32'h19, 2'h0);
    for (int s = 0; s < 3; s++) begin
      wr(8'h20, (s == 2) ? 32'ha : 32'h0, 2'h0);
      arm((s == 1) ? 32'h015 : 32'h011);
      repeat (20) @(posedge CLOCK_I);
      chk("no start", 32'h0, 32'(nval));
      pulse(0);
      repeat (30) @(posedge CLOCK_I);
      chk("pre", 32'h2, 32'(nval));
      t0 = cyc;
      pulse(2);
      while (ndone < 1) @(posedge CLOCK_I);
      tr[s] = cyc - t0;
      chk("record", 32'h8, 32'(nval));
      rd(8'h04, st);
      chk("status", 32'h2, st & 32'h3);
    end
    chk("slope", 32'h5, 32'(tr[1] - tr[0]));
    chk("delay", 32'ha, 32'(tr[2] - tr[0]));
    rdc(8'h30, 32'h1);
    wr(8'h0c, 32'h64, 2'h0);
    for (int s = 0; s < 2; s++) begin
      lvl <= s ? 16'sh00c8 : 16'sh0;
      arm(s ? 32'h006 : 32'h002);
      repeat (40) @(posedge CLOCK_I);
      chk("level wait", 32'h2, 32'(nval));
      lvl <= s ? 16'sh0 : 16'sh00c8;
      repeat (40) @(posedge CLOCK_I);
      chk("level hit", 32'h1, 32'(ndone));
    end
    wr(8'h18, 32'h2, 2'h0);
    arm(32'h040);
    repeat (60) @(posedge CLOCK_I);
    chk("advance wait", 32'h1, 32'(ndone));
    pulse(1);
    repeat (60) @(posedge CLOCK_I);
    chk("advance", 32'h2, 32'(ndone));
    wr(8'h18, 32'h1, 2'h0);
    arm(32'h023);
    repeat (10) @(posedge CLOCK_I);
    chk("sw start wait", 32'h0, 32'(nval));
    wr(8'h00, 32'h8, 2'h0);
    repeat (10) @(posedge CLOCK_I);
    chk("sw start", 32'h2, 32'(nval));
    wr(8'h00, 32'h8, 2'h0);
    repeat (30) @(posedge CLOCK_I);
    chk("sw reference", 32'h1, 32'(ndone));
    wr(8'h18, 32'h2, 2'h0);
    for (int h = 0; h < 2; h++) begin
      wr(8'h1c, h ? 32'h12c : 32'h0, 2'h0);
      arm(32'h000);
      t0 = cyc;
      while (ndone < 2) @(posedge CLOCK_I);
      tr[h] = cyc - t0;
    end
    chk("holdoff", 32'h1, {31'h0, tr[1] - tr[0] inside {[251:300]}});
    arm(32'h010);
    rd(8'h04, st);
    chk("status", 32'h1, st & 32'h3);
    wr(8'h00, 32'h2, 2'h0);
    rd(8'h04, st);
    chk("abort", 32'h0, st & 32'h1f);
    pulse(0);
    repeat (30) @(posedge CLOCK_I);
    chk("abort idle", 32'h0, 32'(nval));
    wr(8'h24, 32'hffffffff, 2'h0);
    wr(8'h08, 32'h012, 2'h0);
    chk("bw pending", 32'h0, BW_SEL_O);
    wr(8'h00, 32'h4, 2'h0);
    @(posedge CLOCK_I);
    chk("bw full", 32'hffffffff, BW_SEL_O);
    rdc(8'h38, 32'h012);
    chk("bypass", 32'h1234, {16'h0, SMP_O});
    wr(8'h2c, 32'h4000, 2'h0);
    wr(8'h28, 32'h1, 2'h0);
    wr(8'h00, 32'h4, 2'h0);
    repeat (20) @(posedge CLOCK_I);
    chk("filter", 32'h091a, {16'h0, SMP_O});
    end_of_test();
  end
endmodule : tb_digitizer_trigger_sequencer
`default_nettype wire
